// ### hdl/rx_status_defines.svh
// Purpose: constants for the receive status monitor
// Assumes: 250 MHz core clock
// Notes: timing figures kept in their own units, cycles derived
`ifndef RX_STATUS_DEFINES_SVH
`define RX_STATUS_DEFINES_SVH

`define CLK_PERIOD_NS 4
`define TICK_NS 1000000
`define MS_CYCLES (`TICK_NS / `CLK_PERIOD_NS)

`define LOS_ZERO_RUN 8'h80
`define LOS_ONES_MIN 6'h30
`define LOS_WIN_BITS 9'h182
`define D4_SET_MS 10'h258
`define D4_CLR_MS 10'h0c8
`define BPV_COARSE 9'h100
`define BPV_HOLD_MS 7'h60
`define DEB_MIN_MS 4'h6

`define STAT_CH_PHASE 5'h03
`define STAT_CH_MSW1 5'h0f
`define STAT_CH_MSW2 5'h1f
`define SIG_A_FIRST 5'h04
`define SIG_A_LAST 5'h0e
`define SIG_B_FIRST 5'h10
`define SIG_B_LAST 5'h1c
`define SIG_CHANNELS 24

`define E8K_RISE_CH 5'h11
`define E8K_RISE_BIT 3'h2
`define E8K_FALL_CH 5'h05

`define ESF_YEL_PATTERN 16'h00ff

`define DEB_REP_MSB 11
`define DEB_PEND_MSB 7
`define DEB_STAMP_MSB 3
`endif

// ### hdl/rx_status_monitor.sv
// Purpose: receive status and alarm monitor, serial status output
// Assumes: line strobes come from framer logic on core_clk_in; bus pins are asynchronous
// Notes: signalling updates pass a 4-deep fifo; framer must honour sig_ready_out
`timescale 1ns/10ps
`include "rx_status_defines.svh"

//Contract
// - frame carries two master, 24 channel, phase
// - signal lost after 128 zeros
// - rails forced high while signal lost
// - 48 ones in two frames clears
// - channel word: zeros, then A B C D
// - optional 6 to 9 ms debounce
// - bit2 zero 600 ms raises alarm
// - alarm clears 200 ms after change
// - eight zeros, eight ones: link alarm
// - mimic set on multiple candidates, cleared resync
// - toggle per 256 violations, 96 ms holdoff
// - fine toggles every 128 and 64
// - phase word in channel three
// - wrap bit toggles on phase wrap
// - 8 kHz rise at channel 17 bit 2
// - store signalling, present every bus frame
// - ESF four valid, D4 only A B
// - freeze signalling while sync lost
// - second master word layout, channel 31
module rx_status_monitor
	import rx_status_pkg::*;
#(
	parameter int MS_CYCLES = `MS_CYCLES,
	parameter int FIFO_DEPTH = 4
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	// line bits from receiver
	input wire logic line_bit_stb_in,
	input wire logic line_mark_in,
	input wire logic rail_a_in,
	input wire logic rail_b_in,
	input wire logic bpv_stb_in,
	input wire logic [4:0] line_chan_in,
	input wire logic [2:0] line_bitpos_in,
	input wire logic frame_stb_in,
	input wire logic ds0_bit2_stb_in,
	input wire logic ds0_bit2_in,
	input wire logic link_bit_stb_in,
	input wire logic facility_link_bits_in,
	// framer state
	input wire logic in_sync_in,
	input wire logic multi_sync_in,
	input wire logic esf_mode_in,
	input wire logic multi_candidate_stb_in,
	input wire logic resync_stb_in,
	input wire logic all_ones_alarm_in,
	input wire logic debounce_en_in,
	// signalling updates
	input wire logic sig_valid_in,
	input wire logic [4:0] sig_chan_in,
	input wire logic [3:0] sig_bits_in,
	output logic sig_ready_out,
	// status bus pins
	input wire logic bus_clk_in,
	input wire logic bus_frame_n_in,
	output logic status_serial_out,
	// line outputs
	output logic signal_lost_flag_out,
	output logic rx_rail_a_n_out,
	output logic rx_rail_b_n_out,
	output logic extracted_8khz_out
);
	localparam int MSW = $clog2(MS_CYCLES + 1);
	initial if (MS_CYCLES < 1 || FIFO_DEPTH < 2) $error("rx_status_monitor: bad parameters");

	// millisecond tick
	logic [MSW-1:0] ms_cnt_q;
	logic ms_tick_q;
	logic [3:0] ms_stamp_q;
	wire ms_wrap = (ms_cnt_q == MSW'(MS_CYCLES - 1));
	always_ff @(posedge core_clk_in or negedge rst_b_in)
		if (!rst_b_in)
		begin
			ms_cnt_q <= '0;
			ms_tick_q <= 1'b0;
			ms_stamp_q <= 4'h0;
		end
		else
		begin
			ms_cnt_q <= ms_wrap ? '0 : ms_cnt_q + MSW'(1);
			ms_tick_q <= ms_wrap;
			ms_stamp_q <= ms_stamp_q + 4'(ms_wrap);
		end

	// signal lost detect
	logic [7:0] zero_run_q;
	logic [8:0] win_q;
	logic [5:0] ones_q;
	logic los_q;
	wire zero_bit = line_bit_stb_in && !line_mark_in;
	wire one_bit = line_bit_stb_in && line_mark_in;
	wire los_set = zero_bit && (zero_run_q == `LOS_ZERO_RUN - 8'h01);
	wire los_clr = los_q && one_bit && (ones_q == `LOS_ONES_MIN - 6'h01);
	wire win_end = line_bit_stb_in && (win_q == `LOS_WIN_BITS - 9'h001);
	always_ff @(posedge core_clk_in or negedge rst_b_in)
		if (!rst_b_in)
		begin
			zero_run_q <= 8'h00;
			win_q <= 9'h000;
			ones_q <= 6'h00;
			los_q <= 1'b0;
		end
		else
		begin
			if (one_bit)
				zero_run_q <= 8'h00;
			else if (zero_bit && zero_run_q != `LOS_ZERO_RUN)
				zero_run_q <= zero_run_q + 8'h01;
			if (!los_q || win_end || los_clr)
			begin
				win_q <= 9'h000;
				ones_q <= 6'h00;
			end
			else if (line_bit_stb_in)
			begin
				win_q <= win_q + 9'h001;
				ones_q <= ones_q + 6'(line_mark_in);
			end
			if (los_set)
				los_q <= 1'b1;
			else if (los_clr)
				los_q <= 1'b0;
		end
	always_ff @(posedge core_clk_in or negedge rst_b_in)
		if (!rst_b_in)
		begin
			rx_rail_a_n_out <= 1'b1;
			rx_rail_b_n_out <= 1'b1;
			signal_lost_flag_out <= 1'b0;
		end
		else
		begin
			rx_rail_a_n_out <= !(rail_a_in && !los_q);
			rx_rail_b_n_out <= !(rail_b_in && !los_q);
			signal_lost_flag_out <= los_q;
		end

	// d4 remote alarm: ms intervals with at least one all-zero frame tolerate errored frames
	logic frame_zero_q;
	logic ms_zero_q;
	logic [9:0] set_ms_q;
	logic [9:0] clr_ms_q;
	logic d4_remote_alarm_q;
	always_ff @(posedge core_clk_in or negedge rst_b_in)
		if (!rst_b_in)
		begin
			frame_zero_q <= 1'b1;
			ms_zero_q <= 1'b0;
			set_ms_q <= 10'h000;
			clr_ms_q <= 10'h000;
			d4_remote_alarm_q <= 1'b0;
		end
		else
		begin
			if (frame_stb_in)
				frame_zero_q <= 1'b1;
			else if (ds0_bit2_stb_in && ds0_bit2_in)
				frame_zero_q <= 1'b0;
			if (ms_tick_q)
				ms_zero_q <= 1'b0;
			else if (frame_stb_in && frame_zero_q)
				ms_zero_q <= 1'b1;
			if (ms_tick_q)
			begin
				set_ms_q <= ms_zero_q ? set_ms_q + 10'(set_ms_q != `D4_SET_MS) : 10'h000;
				clr_ms_q <= ms_zero_q ? 10'h000 : clr_ms_q + 10'(clr_ms_q != `D4_CLR_MS);
			end
			if (set_ms_q == `D4_SET_MS)
				d4_remote_alarm_q <= 1'b1;
			else if (clr_ms_q == `D4_CLR_MS)
				d4_remote_alarm_q <= 1'b0;
		end

	// esf remote alarm; drops on any broken repeat, controller filters it
	logic [15:0] link_shift_q;
	logic [4:0] since_match_q;
	logic esf_remote_alarm_q;
	wire [15:0] link_next = {link_shift_q[14:0], facility_link_bits_in};
	wire link_match = link_bit_stb_in && (link_next == `ESF_YEL_PATTERN);
	always_ff @(posedge core_clk_in or negedge rst_b_in)
		if (!rst_b_in)
		begin
			link_shift_q <= 16'hffff;
			since_match_q <= 5'h00;
			esf_remote_alarm_q <= 1'b0;
		end
		else if (link_bit_stb_in)
		begin
			link_shift_q <= link_next;
			since_match_q <= link_match ? 5'h00 : since_match_q + 5'(since_match_q != 5'h10);
			if (link_match)
				esf_remote_alarm_q <= 1'b1;
			else if (since_match_q == 5'h0f)
				esf_remote_alarm_q <= 1'b0;
		end

	// mimic flag and violation counters
	logic mimic_q;
	logic [8:0] bpv_cnt_q;
	logic [6:0] hold_ms_q;
	logic violation_toggle_q;
	logic [6:0] fine_cnt_q;
	logic [1:0] violation_fine_toggles_q;
	wire coarse_fire = (bpv_cnt_q == `BPV_COARSE) && (hold_ms_q == `BPV_HOLD_MS);
	always_ff @(posedge core_clk_in or negedge rst_b_in)
		if (!rst_b_in)
		begin
			mimic_q <= 1'b0;
			bpv_cnt_q <= 9'h000;
			hold_ms_q <= 7'h00;
			violation_toggle_q <= 1'b0;
			fine_cnt_q <= 7'h00;
			violation_fine_toggles_q <= 2'h0;
		end
		else
		begin
			if (multi_candidate_stb_in)
				mimic_q <= 1'b1;
			else if (resync_stb_in)
				mimic_q <= 1'b0;
			if (coarse_fire)
			begin
				bpv_cnt_q <= 9'h000;
				hold_ms_q <= 7'h00;
				violation_toggle_q <= !violation_toggle_q;
			end
			else
			begin
				if (bpv_stb_in && bpv_cnt_q != `BPV_COARSE)
					bpv_cnt_q <= bpv_cnt_q + 9'h001;
				if (ms_tick_q && hold_ms_q != `BPV_HOLD_MS)
					hold_ms_q <= hold_ms_q + 7'h01;
			end
			if (bpv_stb_in)
			begin
				fine_cnt_q <= fine_cnt_q + 7'h01;
				violation_fine_toggles_q[1] <= violation_fine_toggles_q[1] ^ (fine_cnt_q == 7'h7f);
				violation_fine_toggles_q[0] <= violation_fine_toggles_q[0] ^ (fine_cnt_q[5:0] == 6'h3f);
			end
		end

	// status bus pin synchronisers
	logic [1:0] bclk_sync_q;
	logic [1:0] bfrm_sync_q;
	logic bclk_last_q;
	always_ff @(posedge core_clk_in or negedge rst_b_in)
		if (!rst_b_in)
		begin
			bclk_sync_q <= 2'h0;
			bfrm_sync_q <= 2'h3;
			bclk_last_q <= 1'b0;
		end
		else
		begin
			bclk_sync_q <= {bclk_sync_q[0], bus_clk_in};
			bfrm_sync_q <= {bfrm_sync_q[0], bus_frame_n_in};
			bclk_last_q <= bclk_sync_q[1];
		end
	wire bus_fall = bclk_last_q && !bclk_sync_q[1];
	wire bus_frame = !bfrm_sync_q[1];

	// extracted 8 kHz and phase capture
	logic [7:0] bus_pos_q;
	logic [7:0] phase_q;
	logic phase_wrap_bit_q;
	wire e8k_rise = line_bit_stb_in && line_chan_in == `E8K_RISE_CH && line_bitpos_in == `E8K_RISE_BIT;
	wire e8k_fall = line_bit_stb_in && line_chan_in == `E8K_FALL_CH && line_bitpos_in == `E8K_RISE_BIT;
	wire wrap_up = phase_q[7:6] == 2'h3 && bus_pos_q[7:6] == 2'h0;
	wire wrap_down = phase_q[7:6] == 2'h0 && bus_pos_q[7:6] == 2'h3;
	always_ff @(posedge core_clk_in or negedge rst_b_in)
		if (!rst_b_in)
		begin
			extracted_8khz_out <= 1'b0;
			phase_q <= 8'h00;
			phase_wrap_bit_q <= 1'b0;
		end
		else
		begin
			if (e8k_rise)
				extracted_8khz_out <= 1'b1;
			else if (e8k_fall)
				extracted_8khz_out <= 1'b0;
			if (e8k_rise)
			begin
				phase_q <= bus_pos_q;
				phase_wrap_bit_q <= phase_wrap_bit_q ^ (wrap_up || wrap_down);
			end
		end

	// signalling store path
	upd_state_e upd_q;
	logic [8:0] fifo_data;
	logic fifo_valid;
	logic fifo_pop;
	deb_word_t rd_word;
	deb_word_t wr_word;
	logic wr_en;
	wire [7:0] pos_nxt = bus_frame ? 8'h00 : bus_pos_q + 8'h01;
	wire [4:0] nxt_ch = bus_pos_q[7:3] + 5'h01;
	wire nxt_in_a = nxt_ch >= `SIG_A_FIRST && nxt_ch <= `SIG_A_LAST;
	wire nxt_in_b = nxt_ch >= `SIG_B_FIRST && nxt_ch <= `SIG_B_LAST;
	wire [4:0] nxt_idx = nxt_in_a ? nxt_ch - `SIG_A_FIRST : nxt_ch - `SIG_B_FIRST + 5'h0b;
	// keep rmw clear of the load at a channel edge
	wire upd_start = fifo_valid && bus_pos_q[2:1] != 2'h3;
	wire [4:0] rd_addr = (upd_q == UPD_IDLE) ? nxt_idx : fifo_data[8:4];
	wire [3:0] new_bits = fifo_data[3:0];
	wire [3:0] rep = rd_word[`DEB_REP_MSB:`DEB_REP_MSB-3];
	wire [3:0] pend = rd_word[`DEB_PEND_MSB:`DEB_PEND_MSB-3];
	wire [3:0] age = ms_stamp_q - rd_word[`DEB_STAMP_MSB:0];
	wire settled = new_bits == pend && age >= `DEB_MIN_MS;
	assign fifo_pop = (upd_q == UPD_MOD);
	assign wr_en = fifo_pop && in_sync_in;
	assign wr_word = !debounce_en_in ? {new_bits, new_bits, ms_stamp_q} :
		(new_bits == rep) ? {rep, new_bits, ms_stamp_q} :
		(new_bits != pend) ? {rep, new_bits, ms_stamp_q} :
		settled ? {new_bits, pend, rd_word[3:0]} : rd_word;
	always_ff @(posedge core_clk_in or negedge rst_b_in)
		if (!rst_b_in)
			upd_q <= UPD_IDLE;
		else
			case (upd_q)
				UPD_IDLE: upd_q <= upd_start ? UPD_READ : UPD_IDLE;
				UPD_READ: upd_q <= UPD_MOD;
				UPD_MOD: upd_q <= UPD_IDLE;
				default: upd_q <= UPD_IDLE;
			endcase

	sig_fifo #(
		.WIDTH(9),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk_in(core_clk_in),
		.rst_b_in(rst_b_in),
		.in_valid_in(sig_valid_in),
		.in_data_in({sig_chan_in, sig_bits_in}),
		.in_ready_out(sig_ready_out),
		.out_valid_out(fifo_valid),
		.out_data_out(fifo_data),
		.out_ready_in(fifo_pop)
	);

	sig_mem #(
		.WIDTH(12),
		.DEPTH(`SIG_CHANNELS)
	) u_mem (
		.core_clk_in(core_clk_in),
		.wr_en_in(wr_en),
		.wr_addr_in(fifo_data[8:4]),
		.wr_data_in(wr_word),
		.rd_addr_in(rd_addr),
		.rd_data_out(rd_word)
	);

	// status serialiser
	logic [7:0] shift_q;
	wire [3:0] rep_valid = esf_mode_in ? rep : {rep[3:2], 2'h0};
	wire [7:0] msw1 = {d4_remote_alarm_q, mimic_q, 1'b0, esf_remote_alarm_q,
		!multi_sync_in, violation_toggle_q, 1'b0, !in_sync_in};
	wire [7:0] msw2 = {all_ones_alarm_in, phase_wrap_bit_q, 1'b0, violation_fine_toggles_q, 3'h0};
	wire [4:0] load_ch = pos_nxt[7:3];
	wire [7:0] load_word = (load_ch == `STAT_CH_PHASE) ? phase_q :
		(load_ch == `STAT_CH_MSW1) ? msw1 :
		(load_ch == `STAT_CH_MSW2) ? msw2 :
		(!bus_frame && (nxt_in_a || nxt_in_b)) ? {4'h0, rep_valid} : 8'h00;
	always_ff @(posedge core_clk_in or negedge rst_b_in)
		if (!rst_b_in)
		begin
			bus_pos_q <= 8'hff;
			shift_q <= 8'h00;
			status_serial_out <= 1'b0;
		end
		else if (bus_fall)
		begin
			bus_pos_q <= pos_nxt;
			if (pos_nxt[2:0] == 3'h0)
			begin
				shift_q <= {load_word[6:0], 1'b0};
				status_serial_out <= load_word[7];
			end
			else
			begin
				shift_q <= {shift_q[6:0], 1'b0};
				status_serial_out <= shift_q[7];
			end
		end
endmodule : rx_status_monitor

// ### hdl/rx_status_pkg.sv
// Purpose: types for the receive status monitor
// Assumes: nothing
// Notes: constants live in rx_status_defines.svh
package rx_status_pkg;
	typedef enum logic [2:0] {
		UPD_IDLE = 3'b001,
		UPD_READ = 3'b010,
		UPD_MOD = 3'b100
	} upd_state_e;
	typedef logic [11:0] deb_word_t;
endpackage : rx_status_pkg

// ### hdl/sig_fifo.sv
// Purpose: small fifo for signalling updates
// Assumes: one clock
// Notes: in_ready_out registered
`timescale 1ns/10ps
module sig_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	// fill side
	input wire logic in_valid_in,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic in_ready_out,
	// drain side
	output logic out_valid_out,
	output logic [WIDTH-1:0] out_data_out,
	input wire logic out_ready_in
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	initial if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) $error("sig_fifo: DEPTH must be power of two >= 2");
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	wire push = in_valid_in && in_ready_out;
	wire pop = out_valid_out && out_ready_in;
	assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	assign out_valid_out = (cnt_q != '0);
	assign out_data_out = mem_q[rd_q];
	always_ff @(posedge core_clk_in or negedge rst_b_in)
		if (!rst_b_in)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			in_ready_out <= 1'b1;
		end
		else
		begin
			wr_q <= wr_q + AW'(push);
			rd_q <= rd_q + AW'(pop);
			cnt_q <= cnt_d;
			in_ready_out <= (cnt_d != (AW+1)'(DEPTH));
		end
	always_ff @(posedge core_clk_in)
		if (push)
			mem_q[wr_q] <= in_data_in;
endmodule : sig_fifo

// ### hdl/sig_mem.sv
// Purpose: per-channel signalling store
// Assumes: one write and one read port
// Notes: read data registered every cycle
`timescale 1ns/10ps
module sig_mem #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 24
) (
	// clock
	input wire logic core_clk_in,
	// write port
	input wire logic wr_en_in,
	input wire logic [4:0] wr_addr_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	// read port
	input wire logic [4:0] rd_addr_in,
	output logic [WIDTH-1:0] rd_data_out
);
	initial if (DEPTH > 32 || DEPTH < 1) $error("sig_mem: DEPTH out of range");
	logic [WIDTH-1:0] mem_q [DEPTH];
	// no reset on the array; contents valid after first update per channel
	always_ff @(posedge core_clk_in)
	begin
		if (wr_en_in)
			mem_q[wr_addr_in] <= wr_data_in;
		rd_data_out <= mem_q[rd_addr_in];
	end
endmodule : sig_mem

// ### verif/rx_status_chk_monitor.sv
// Purpose: port assertions for the receive status monitor
// Assumes: line strobes at most one per cycle
// Notes: bound into every rx_status_monitor instance
`timescale 1ns/10ps
module rx_status_chk #(
	parameter int MS_CYCLES = 250000
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	// line side
	input wire logic line_bit_stb_in,
	input wire logic line_mark_in,
	input wire logic rail_a_in,
	input wire logic rail_b_in,
	input wire logic [4:0] line_chan_in,
	input wire logic [2:0] line_bitpos_in,
	// outputs watched
	input wire logic signal_lost_flag_out,
	input wire logic rx_rail_a_n_out,
	input wire logic rx_rail_b_n_out,
	input wire logic extracted_8khz_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	logic [7:0] zrun_q;
	logic [9:0] ones_q;
	logic rise_hit_q;
	wire zero_stb = line_bit_stb_in && !line_mark_in;
	wire one_stb = line_bit_stb_in && line_mark_in;
	wire rise_pos = line_bit_stb_in && (line_chan_in == 5'h11) && (line_bitpos_in == 3'h2);
	// saturating, so a long run cannot wrap into a false count
	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			zrun_q <= 8'h00;
			ones_q <= 10'h000;
			rise_hit_q <= 1'b0;
		end
		else
		begin
			zrun_q <= one_stb ? 8'h00 : (zero_stb && zrun_q != 8'hff) ? zrun_q + 8'h01 : zrun_q;
			ones_q <= !signal_lost_flag_out ? 10'h000 : (one_stb && ones_q != 10'h3ff) ? ones_q + 10'h001 : ones_q;
			rise_hit_q <= rise_pos;
		end
	end
	property p_lost_set;
		zero_stb && zrun_q == 8'h7f && !signal_lost_flag_out |-> ##[1:2] signal_lost_flag_out;
	endproperty
	a_lost_set: assert property (p_lost_set) else $error("signal lost not raised after zero run");
	property p_lost_cause;
		$rose(signal_lost_flag_out) |-> $past(zero_stb, 2) && $past(zrun_q, 2) == 8'h7f;
	endproperty
	a_lost_cause: assert property (p_lost_cause) else $error("signal lost raised too early");
	property p_one_blocks;
		one_stb && !signal_lost_flag_out && zrun_q < 8'h80 |=> !signal_lost_flag_out;
	endproperty
	a_one_blocks: assert property (p_one_blocks) else $error("signal lost raised after a one");
	property p_lost_clear;
		$fell(signal_lost_flag_out) |-> ones_q >= 10'h030;
	endproperty
	a_lost_clear: assert property (p_lost_clear) else $error("signal lost cleared with too few ones");
	property p_rails_forced;
		signal_lost_flag_out && $past(signal_lost_flag_out) |-> rx_rail_a_n_out && rx_rail_b_n_out;
	endproperty
	a_rails_forced: assert property (p_rails_forced) else $error("rails not forced while lost");
	property p_rails_pass;
		!signal_lost_flag_out && !$past(signal_lost_flag_out) |->
			rx_rail_a_n_out == !$past(rail_a_in) && rx_rail_b_n_out == !$past(rail_b_in);
	endproperty
	a_rails_pass: assert property (p_rails_pass) else $error("rails do not follow the line");
	property p_e8k_rise;
		rise_hit_q |-> extracted_8khz_out;
	endproperty
	a_e8k_rise: assert property (p_e8k_rise) else $error("8 kHz not high after its bit");
	property p_e8k_cause;
		$rose(extracted_8khz_out) |-> rise_hit_q;
	endproperty
	a_e8k_cause: assert property (p_e8k_cause) else $error("8 kHz rose at the wrong bit");
endmodule : rx_status_chk
bind rx_status_monitor rx_status_chk #(.MS_CYCLES(MS_CYCLES)) rx_status_chk_i (
	.core_clk_in(core_clk_in),
	.rst_b_in(rst_b_in),
	.line_bit_stb_in(line_bit_stb_in),
	.line_mark_in(line_mark_in),
	.rail_a_in(rail_a_in),
	.rail_b_in(rail_b_in),
	.line_chan_in(line_chan_in),
	.line_bitpos_in(line_bitpos_in),
	.signal_lost_flag_out(signal_lost_flag_out),
	.rx_rail_a_n_out(rx_rail_a_n_out),
	.rx_rail_b_n_out(rx_rail_b_n_out),
	.extracted_8khz_out(extracted_8khz_out)
);

// ### verif/status_bus_reader.sv
// Purpose: controller model reading the serial status bus
// Assumes: bus clock free-runs at 60 ns, unlocked to the line
// Notes: faster than a real bus to keep frames short
`timescale 1ns/10ps
module status_bus_reader (
	// serial status from device
	input wire logic status_in,
	// bus timing to device
	output logic bus_clk_out,
	output logic bus_frame_n_out,
	// captured frames
	output logic [255:0] frame_out,
	output logic [7:0] pos_out,
	output logic [7:0] frame_cnt_out
);
	logic [255:0] shift_q;
	initial
	begin
		bus_clk_out = 1'b1;
		bus_frame_n_out = 1'b1;
		frame_out = '0;
		pos_out = 8'hff;
		frame_cnt_out = 8'h00;
		shift_q = '0;
		forever
		begin
			#15;
			bus_frame_n_out = (pos_out != 8'hff);
			#15;
			bus_clk_out = 1'b0;
			pos_out = pos_out + 8'h01;
			#15;
			bus_frame_n_out = 1'b1;
			#15;
			// sample half a bit after the fall, output long settled
			bus_clk_out = 1'b1;
			shift_q = {shift_q[254:0], status_in};
			if (pos_out == 8'hff)
			begin
				frame_out = shift_q;
				frame_cnt_out = frame_cnt_out + 8'h01;
			end
		end
	end
endmodule : status_bus_reader

// ### verif/t1_receive_status_monitor_tb.sv
// Purpose: self-checking bench for the receive status monitor
// Assumes: ms timers scaled down through MS_CYCLES
// Notes: frame and bit-2 inputs tied off, so the d4 alarm stays low
`timescale 1ns/10ps
module t1_receive_status_monitor_tb;
	typedef struct {logic [4:0] c; logic [3:0] b; logic [4:0] sc; logic [7:0] e;} row_s;
	row_s rows [6] = '{'{5'h00, 4'ha, 5'h04, 8'h0a}, '{5'h0a, 4'h5, 5'h0e, 8'h05}, '{5'h0b, 4'hf, 5'h10, 8'h0f},
		'{5'h17, 4'h3, 5'h1c, 8'h03}, '{5'h05, 4'h9, 5'h09, 8'h09}, '{5'h0c, 4'h6, 5'h11, 8'h06}};
	logic clk, rst_b, bit_stb, mark, rail_a, rail_b, violation_toggle, link_stb, link_bit, in_sync, m_sync, esf, deb;
	logic cand, resync, blue, sig_valid, fill_seen, sig_ready, bus_clk, frame_n, status, lost, ra_n, rb_n, e8k;
	logic [4:0] chan, sig_chan;
	logic [2:0] bpos;
	logic [3:0] sig_bits;
	logic [255:0] frame;
	logic [7:0] pos, fcnt;
	int n_fail, total_checks, cyc;
	rx_status_monitor #(.MS_CYCLES(10), .FIFO_DEPTH(4)) rx_status_monitor_i (.core_clk_in(clk), .rst_b_in(rst_b),
		.line_bit_stb_in(bit_stb), .line_mark_in(mark), .rail_a_in(rail_a), .rail_b_in(rail_b), .bpv_stb_in(violation_toggle),
		.line_chan_in(chan), .line_bitpos_in(bpos), .frame_stb_in(1'b0), .ds0_bit2_stb_in(1'b0), .ds0_bit2_in(1'b0),
		.link_bit_stb_in(link_stb), .facility_link_bits_in(link_bit), .in_sync_in(in_sync), .multi_sync_in(m_sync),
		.esf_mode_in(esf), .multi_candidate_stb_in(cand), .resync_stb_in(resync), .all_ones_alarm_in(blue),
		.debounce_en_in(deb), .sig_valid_in(sig_valid), .sig_chan_in(sig_chan), .sig_bits_in(sig_bits),
		.sig_ready_out(sig_ready), .bus_clk_in(bus_clk), .bus_frame_n_in(frame_n), .status_serial_out(status),
		.signal_lost_flag_out(lost), .rx_rail_a_n_out(ra_n), .rx_rail_b_n_out(rb_n), .extracted_8khz_out(e8k));
	status_bus_reader status_bus_reader_i (.status_in(status), .bus_clk_out(bus_clk), .bus_frame_n_out(frame_n),
		.frame_out(frame), .pos_out(pos), .frame_cnt_out(fcnt));
	task tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	task check(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	function logic [7:0] st(input int ch);
		return frame[255-8*ch -: 8];
	endfunction : st
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	// two full frames, so the one captured started after the change
	task read_frame;
		logic [7:0] c;
		c = fcnt;
		wait (fcnt == c + 8'h02);
		tick(1);
	endtask : read_frame
	task line(input int n, input logic m);
		repeat (n)
		begin
			bit_stb = 1'b1;
			mark = m;
			tick(1);
			bit_stb = 1'b0;
			tick(1);
		end
	endtask : line
	task viol(input int n);
		repeat (n)
		begin
			violation_toggle = 1'b1;
			tick(1);
			violation_toggle = 1'b0;
			tick(1);
		end
	endtask : viol
	// leaves valid high so callers can stream back to back
	task put(input logic [4:0] c, input logic [3:0] b);
		sig_valid = 1'b1;
		sig_chan = c;
		sig_bits = b;
		@(posedge clk);
		while (sig_ready !== 1'b1)
		begin
			fill_seen = 1'b1;
			@(posedge clk);
		end
		#1;
	endtask : put
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			n_fail++;
			tally_and_finish;
		end
	end
	initial
	begin
		{rst_b, bit_stb, mark, rail_a, rail_b, violation_toggle, link_stb, link_bit, esf, cand, resync, blue, deb} = '0;
		{sig_valid, fill_seen, chan, bpos, sig_chan, sig_bits} = '0;
		{in_sync, m_sync} = 2'b11;
		tick(8);
		check({3'h0, lost, ra_n, rb_n, e8k, sig_ready}, 8'h0d);
		rst_b = 1'b1;
		tick(1);
		check({3'h0, lost, ra_n, rb_n, e8k, sig_ready}, 8'h0d);
		esf = 1'b1;
		foreach (rows[i]) put(rows[i].c, rows[i].b);
		sig_valid = 1'b0;
		check({7'h0, fill_seen}, 8'h01);
		read_frame;
		foreach (rows[i]) check(st(rows[i].sc), rows[i].e);
		check(st(15), 8'h00);
		esf = 1'b0;
		read_frame;
		check(st(4), 8'h08);
		in_sync = 1'b0;
		put(5'h00, 4'h5);
		sig_valid = 1'b0;
		tick(10);
		read_frame;
		check(st(4), 8'h08);
		check(st(15), 8'h01);
		in_sync = 1'b1;
		put(5'h00, 4'h5);
		sig_valid = 1'b0;
		m_sync = 1'b0;
		cand = 1'b1;
		tick(1);
		cand = 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			link_stb = 1'b1;
			link_bit = i < 8;
			tick(1);
			link_stb = 1'b0;
			tick(1);
		end
		blue = 1'b1;
		read_frame;
		check(st(4), 8'h04);
		check(st(15), 8'h58);
		check(st(31) & 8'h80, 8'h80);
		resync = 1'b1;
		tick(1);
		{resync, blue, m_sync, deb} = 4'b0011;
		// first sighting only arms the debounce
		put(5'h00, 4'hc);
		sig_valid = 1'b0;
		viol(255);
		read_frame;
		check(st(4), 8'h04);
		check(st(15), 8'h10);
		check(st(31) & 8'h98, 8'h18);
		viol(1);
		// repeats a ms apart, so one lands in the settle window
		repeat (16)
		begin
			put(5'h00, 4'hc);
			sig_valid = 1'b0;
			tick(10);
		end
		tick(1000);
		read_frame;
		check(st(15) & 8'h04, 8'h04);
		check(st(4), 8'h0c);
		check(st(31) & 8'h18, 8'h00);
		// first capture wraps down from the reset reading of zero
		for (int k = 0; k < 2; k++)
		begin
			wait (pos == ((k == 0) ? 8'he0 : 8'h64));
			#30;
			tick(1);
			{chan, bpos} = {5'h11, 3'h2};
			line(1, 1'b1);
			check({7'h0, e8k}, 8'h01);
			{chan, bpos} = {5'h05, 3'h2};
			line(1, 1'b1);
			check({7'h0, e8k}, 8'h00);
		end
		{chan, bpos} = '0;
		read_frame;
		check(st(3), 8'h64);
		check(st(31) & 8'h40, 8'h40);
		line(127, 1'b0);
		line(1, 1'b1);
		line(127, 1'b0);
		check({7'h0, lost}, 8'h00);
		line(1, 1'b0);
		check({7'h0, lost}, 8'h01);
		{rail_a, rail_b} = 2'b11;
		tick(2);
		check({6'h0, ra_n, rb_n}, 8'h03);
		line(400, 1'b1);
		check({5'h0, lost, ra_n, rb_n}, 8'h00);
		tally_and_finish;
	end
endmodule : t1_receive_status_monitor_tb
